// ---- inc/tmr16_pkg.sv ----
package tmr16_pkg;

    // ------------------------------------------------------------------
    // Register word offsets (byte addresses on APB)
    // ------------------------------------------------------------------
    localparam logic [7:0] TMR16_CTRLA_OFF   = 8'h00;
    localparam logic [7:0] TMR16_CTRLB_OFF   = 8'h04;
    localparam logic [7:0] TMR16_CNTL_OFF    = 8'h08;
    localparam logic [7:0] TMR16_CNTH_OFF    = 8'h0c;
    localparam logic [7:0] TMR16_CAPL_OFF    = 8'h10;
    localparam logic [7:0] TMR16_CAPH_OFF    = 8'h14;
    localparam logic [7:0] TMR16_CMPL_OFF    = 8'h18;
    localparam logic [7:0] TMR16_CMPH_OFF    = 8'h1c;
    localparam logic [7:0] TMR16_FLAG_OFF    = 8'h20;
    localparam logic [7:0] TMR16_MASK_OFF    = 8'h24;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int TMR16_WGM_LO_POS = 0;   // Control A bits 1:0 = mode bits 1:0
    localparam int TMR16_CS_POS     = 0;   // Control B bits 2:0 clock select
    localparam int TMR16_WGM_HI_POS = 3;   // Control B bits 4:3 = mode bits 3:2
    localparam int TMR16_EDGE_POS   = 6;   // Control B bit 6 capture edge, 1 = rising
    localparam int TMR16_SRC_POS    = 7;   // Control B bit 7 comparator as source
    localparam int TMR16_OVF_POS    = 0;
    localparam int TMR16_CAPF_POS   = 1;

    // ------------------------------------------------------------------
    // Reset values and fixed tops
    // ------------------------------------------------------------------
    localparam logic [7:0]  TMR16_BYTE_RST = 8'h00;
    localparam logic [15:0] TMR16_WORD_RST = 16'h0000;
    localparam logic [15:0] TMR16_MAX      = 16'hffff;
    localparam logic [15:0] TMR16_TOP8     = 16'h00ff;
    localparam logic [15:0] TMR16_TOP9     = 16'h01ff;
    localparam logic [15:0] TMR16_TOP10    = 16'h03ff;
    localparam logic [2:0]  TMR16_CS_OFF   = 3'h0;

    // Waveform modes that take their top from the capture register
    localparam logic [3:0] TMR16_WGM_PFC_CAP  = 4'h8;
    localparam logic [3:0] TMR16_WGM_PC_CAP   = 4'ha;
    localparam logic [3:0] TMR16_WGM_CTC_CAP  = 4'hc;
    localparam logic [3:0] TMR16_WGM_FAST_CAP = 4'he;

    typedef enum logic [1:0] {TMR16_DIR_UP, TMR16_DIR_DOWN} tmr16_dir_t;

endpackage : tmr16_pkg

// ---- hdl/tmr16_core.sv ----
// Local design decisions: register access over APB and the register offsets.
`timescale 1ns/100ps
// Functional notes
// - Counter seen as high and low bytes
// - High-byte location accesses temporary register
// - Low-byte read copies high into temporary
// - Low-byte write loads whole word at once
// - Each strobe with a clock selected clears, increments or decrements counter
// - Clock select zero stops the counter
// - Counter accessible whether running or stopped
// - Processor write beats counter operations
// - Waveform mode bits choose count sequence
// - Overflow flag set per mode, can interrupt
// - Count steps one, direction picks sense
// - Bottom at zero, top at sequence end
// - Capture source pin or comparator (instance one)
// - Matching edge copies counter to capture register, except in capture-top modes
// - Capture flag set with the copy
// - Enabled capture flag requests interrupt, auto-clears
// - Writing one clears the capture flag
// - Capture low read first latches high byte
// - Capture writable only in capture-top modes
// - Temporary register keeps value between accesses
// - One temporary register shared per instance
// - Compare reads bypass temporary register
module tmr16_core
    import tmr16_pkg::*;
#(
    parameter int  DATA_W      = 8,
    parameter bit  HAS_CMP_SRC = 1'b1
) (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        timerClockStrobe,
    input  wire logic        captureInputPin,
    input  wire logic        comparatorOutput,
    input  wire logic        captureIrqAck,
    output logic             overflowIrq,
    output logic             captureIrq,
    output logic [15:0]      counterValue
);

    initial begin
        if (DATA_W != 8) $error("tmr16_core supports an 8-bit data path only");
    end

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0]  ctrlA;
        logic [7:0]  ctrlB;
        logic [15:0] counter;
        logic [15:0] capture;
        logic [15:0] compare;
        logic [7:0]  temp;
        logic        ovfFlag;
        logic        capFlag;
        logic        ovfEn;
        logic        capEn;
        logic        srcPrev;
        logic        waited;
        tmr16_dir_t  dir;
        logic [31:0] rdata;
    } tmr16_state_t;

    tmr16_state_t state_reg;
    tmr16_state_t state_next;

    function automatic logic usesCapTop(input logic [3:0] m);
        return (m == TMR16_WGM_PFC_CAP) || (m == TMR16_WGM_PC_CAP) ||
               (m == TMR16_WGM_CTC_CAP) || (m == TMR16_WGM_FAST_CAP);
    endfunction : usesCapTop

    logic [3:0]  wgm;
    logic [15:0] topVal;
    logic        dualSlope;
    logic        atTop;
    logic        atBottom;
    logic        access;
    logic        wrAcc;
    logic        rdAcc;
    logic        rdFirst;
    logic        wrDone;
    logic        capSrc;
    logic        capEvent;
    logic        mapped;
    logic [7:0]  wb;

    assign wgm = {state_reg.ctrlB[TMR16_WGM_HI_POS +: 2], state_reg.ctrlA[TMR16_WGM_LO_POS +: 2]};
    assign access  = psel && penable;
    assign wrAcc   = access && pwrite;
    assign rdAcc   = access && !pwrite;
    assign wb      = pwdata[7:0];
    // One wait state lets registered read data stand at the completing edge
    assign rdFirst = rdAcc && !state_reg.waited;
    assign wrDone  = wrAcc && state_reg.waited;
    assign pready  = access && state_reg.waited;
    assign pslverr = 1'b0;
    assign prdata  = state_reg.rdata;
    assign counterValue = state_reg.counter;

    // ------------------------------------------------------------------
    // Sequence decode
    // ------------------------------------------------------------------
    always_comb begin
        unique case (wgm)
            4'h1, 4'h5: topVal = TMR16_TOP8;
            4'h2, 4'h6: topVal = TMR16_TOP9;
            4'h3, 4'h7: topVal = TMR16_TOP10;
            4'h4, 4'h9, 4'hb, 4'hf: topVal = state_reg.compare;
            4'h8, 4'ha, 4'hc, 4'he: topVal = state_reg.capture;
            default: topVal = TMR16_MAX;
        endcase
    end

    assign dualSlope = (wgm inside {4'h1, 4'h2, 4'h3, 4'h8, 4'h9, 4'ha, 4'hb});
    assign atTop     = (state_reg.counter == topVal);
    assign atBottom  = (state_reg.counter == TMR16_WORD_RST);

    // Comparator path only exists on the first instance
    assign capSrc   = (HAS_CMP_SRC && state_reg.ctrlB[TMR16_SRC_POS]) ?
                      comparatorOutput : captureInputPin;
    // Edge detector is off while the capture register serves as top
    assign capEvent = !usesCapTop(wgm) && (capSrc != state_reg.srcPrev) &&
                      (capSrc == state_reg.ctrlB[TMR16_EDGE_POS]);

    assign mapped = paddr inside {TMR16_CTRLA_OFF, TMR16_CTRLB_OFF, TMR16_CNTL_OFF,
                                  TMR16_CNTH_OFF, TMR16_CAPL_OFF, TMR16_CAPH_OFF,
                                  TMR16_CMPL_OFF, TMR16_CMPH_OFF, TMR16_FLAG_OFF,
                                  TMR16_MASK_OFF};

    // ------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------
    always_comb begin
        logic ovfSet;
        ovfSet = 1'b0;
        state_next = state_reg;
        state_next.srcPrev = capSrc;
        state_next.waited  = access && !state_reg.waited;

        // Counting, only on a strobe with a clock source selected
        if (timerClockStrobe && state_reg.ctrlB[TMR16_CS_POS +: 3] != TMR16_CS_OFF) begin
            if (dualSlope) begin
                if (atTop) begin
                    state_next.dir = TMR16_DIR_DOWN;
                    state_next.counter = state_reg.counter - 16'h0001;
                end else if (atBottom && state_reg.dir == TMR16_DIR_DOWN) begin
                    state_next.dir = TMR16_DIR_UP;
                    state_next.counter = state_reg.counter + 16'h0001;
                    ovfSet = 1'b1;
                end else if (state_reg.dir == TMR16_DIR_DOWN) begin
                    state_next.counter = state_reg.counter - 16'h0001;
                end else begin
                    state_next.counter = state_reg.counter + 16'h0001;
                end
            end else if (atTop) begin
                state_next.counter = TMR16_WORD_RST;
                state_next.dir = TMR16_DIR_UP;
                if (wgm != 4'h4 && wgm != 4'hc) ovfSet = 1'b1;
            end else begin
                state_next.counter = state_reg.counter + 16'h0001;
                if (state_reg.counter == TMR16_MAX) ovfSet = 1'b1;
            end
        end

        // Interrupt acknowledge clears the capture flag
        if (captureIrqAck) state_next.capFlag = 1'b0;

        // Register writes; counter write overrides counting
        if (wrDone && mapped) begin
            unique case (paddr)
                TMR16_CTRLA_OFF: state_next.ctrlA = wb;
                TMR16_CTRLB_OFF: state_next.ctrlB = wb;
                TMR16_CNTH_OFF, TMR16_CAPH_OFF, TMR16_CMPH_OFF:
                    state_next.temp = wb;
                TMR16_CNTL_OFF: state_next.counter = {state_reg.temp, wb};
                TMR16_CAPL_OFF: begin
                    if (usesCapTop(wgm)) state_next.capture = {state_reg.temp, wb};
                end
                TMR16_CMPL_OFF: state_next.compare = {state_reg.temp, wb};
                TMR16_FLAG_OFF: begin
                    if (wb[TMR16_OVF_POS]) state_next.ovfFlag = 1'b0;
                    if (wb[TMR16_CAPF_POS]) state_next.capFlag = 1'b0;
                end
                TMR16_MASK_OFF: begin
                    state_next.ovfEn = wb[TMR16_OVF_POS];
                    state_next.capEn = wb[TMR16_CAPF_POS];
                end
                default: ;
            endcase
        end

        // Reads; temporary register otherwise holds its value
        // A set from the counter wins over a coincident software clear
        if (ovfSet) state_next.ovfFlag = 1'b1;

        if (rdFirst) begin
            state_next.rdata = 32'h0000_0000;
            unique case (paddr)
                TMR16_CTRLA_OFF: state_next.rdata[7:0] = state_reg.ctrlA;
                TMR16_CTRLB_OFF: state_next.rdata[7:0] = state_reg.ctrlB;
                TMR16_CNTL_OFF: begin
                    state_next.rdata[7:0] = state_reg.counter[7:0];
                    state_next.temp = state_reg.counter[15:8];
                end
                TMR16_CAPL_OFF: begin
                    state_next.rdata[7:0] = state_reg.capture[7:0];
                    state_next.temp = state_reg.capture[15:8];
                end
                TMR16_CNTH_OFF, TMR16_CAPH_OFF:
                    state_next.rdata[7:0] = state_reg.temp;
                TMR16_CMPL_OFF: state_next.rdata[7:0] = state_reg.compare[7:0];
                TMR16_CMPH_OFF: state_next.rdata[7:0] = state_reg.compare[15:8];
                TMR16_FLAG_OFF: begin
                    state_next.rdata[TMR16_OVF_POS]  = state_reg.ovfFlag;
                    state_next.rdata[TMR16_CAPF_POS] = state_reg.capFlag;
                end
                TMR16_MASK_OFF: begin
                    state_next.rdata[TMR16_OVF_POS]  = state_reg.ovfEn;
                    state_next.rdata[TMR16_CAPF_POS] = state_reg.capEn;
                end
                default: ;
            endcase
        end

        // Capture last so a coincident clear loses to the event
        if (capEvent) begin
            state_next.capture = state_reg.counter;
            state_next.capFlag = 1'b1;
        end
    end

    assign overflowIrq = state_reg.ovfFlag && state_reg.ovfEn;
    assign captureIrq  = state_reg.capFlag && state_reg.capEn;

    always_ff @(posedge clock) begin
        if (srst) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    a_cnt_write_wins: assert property (wrDone && paddr == TMR16_CNTL_OFF |=>
        counterValue == {$past(state_reg.temp), $past(wb)})
        else $error("counter low write did not load word");
    a_low_read_temp: assert property (rdFirst && paddr == TMR16_CNTL_OFF |=>
        state_reg.temp == $past(counterValue[15:8]))
        else $error("counter low read did not latch high byte");
    a_stopped_hold: assert property (state_reg.ctrlB[2:0] == TMR16_CS_OFF && !wrAcc |=>
        $stable(counterValue))
        else $error("counter moved while stopped");
    a_capture_copy: assert property (capEvent |=>
        state_reg.capture == $past(counterValue) && state_reg.capFlag)
        else $error("capture copy or flag missing");
    a_capflag_clear: assert property (wrDone && paddr == TMR16_FLAG_OFF && wb[1] && !capEvent
        |=> !state_reg.capFlag)
        else $error("capture flag not cleared");
    a_capw_blocked: assert property (wrDone && paddr == TMR16_CAPL_OFF && !usesCapTop(wgm)
        && !capEvent |=> $stable(state_reg.capture))
        else $error("capture written in wrong mode");
    a_cmp_read: assert property (rdFirst && paddr == TMR16_CMPH_OFF |=>
        prdata[7:0] == $past(state_reg.compare[15:8]) && $stable(state_reg.temp))
        else $error("compare read touched temporary");
    a_temp_hold: assert property (!access |=> $stable(state_reg.temp))
        else $error("temporary changed without access");
    a_step_one: assert property (timerClockStrobe && !wrAcc && !atTop && !atBottom
        && state_reg.ctrlB[2:0] != TMR16_CS_OFF |=>
        (counterValue - $past(counterValue) == 16'h0001) ||
        ($past(counterValue) - counterValue == 16'h0001))
        else $error("counter step not one");
    a_cap_irq: assert property (captureIrqAck && !capEvent |=> !captureIrq)
        else $error("capture irq not cleared by acknowledge");

    c_capture: cover property (capEvent ##1 captureIrq);
    c_overflow: cover property ($rose(state_reg.ovfFlag));
    c_word_read: cover property (rdFirst && paddr == TMR16_CAPL_OFF ##[1:8]
        rdFirst && paddr == TMR16_CAPH_OFF);
    c_down: cover property (state_reg.dir == TMR16_DIR_DOWN);

endmodule : tmr16_core

// ---- tb/tmr16_cpu_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// Interrupt side of the processor core
// ----------------------------------------
// The handler never touches the shared high byte, so main code needs no guard
module tmr16_cpu_model #(
    parameter int LAT = 3
) (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic irq,
    input  wire logic enable,
    output logic      ack
);
    int waitCnt;

    always @(posedge clock) begin
        ack <= 1'b0;
        if (srst || !irq || !enable) begin
            waitCnt <= 0;
        end else if (waitCnt == LAT) begin
            ack     <= 1'b1;
            waitCnt <= 0;
        end else begin
            waitCnt <= waitCnt + 1;
        end
    end
endmodule : tmr16_cpu_model

// ---- tb/tmr16_core_tb.sv ----
`timescale 1ns/100ps
module tmr16_core_tb
    import tmr16_pkg::*;
;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic        strobe = 1'b0;
    logic        capPin = 1'b0;
    logic        cmpOut = 1'b0;
    logic        ackEnable = 1'b0;
    logic [31:0] prdata;
    logic        pready;
    logic        ovfIrq;
    logic        capIrq;
    logic        capAck;
    logic [15:0] counterValue;
    logic [15:0] lastCv;
    logic [7:0]  rdData;
    int          badCount = 0;
    int          checks = 0;
    int          cycles = 0;

    always #10 clock = ~clock;

    tmr16_core dut (.clock(clock), .srst(srst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(), .timerClockStrobe(strobe),
        .captureInputPin(capPin), .comparatorOutput(cmpOut),
        .captureIrqAck(capAck), .overflowIrq(ovfIrq), .captureIrq(capIrq),
        .counterValue(counterValue));

    tmr16_cpu_model #(.LAT(3)) cpu (.clock(clock), .srst(srst), .irq(capIrq),
        .enable(ackEnable), .ack(capAck));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            badCount++;
            $display("MISMATCH t=%0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    // Read data is taken at the edge where pready is seen high
    task automatic apb(input logic wr, input logic [7:0] addr, input logic [7:0] data);
        int n;
        n = 0;
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= addr;
        pwdata  <= {24'h0, data};
        @(posedge clock);
        penable <= 1'b1;
        @(posedge clock);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clock);
        end
        if (n == 50) badCount++;
        rdData = prdata[7:0];
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clock);
        lastCv = counterValue;
    endtask : apb

    task automatic ticks(input int k);
        strobe <= 1'b1;
        repeat (k) @(posedge clock);
        strobe <= 1'b0;
        @(posedge clock);
    endtask : ticks

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            badCount++;
            report_and_stop();
        end
    end

    initial begin
        repeat (4) @(posedge clock);
        srst <= 1'b0;
        @(posedge clock);
        check(counterValue, TMR16_WORD_RST, "reset count");
        apb(1'b0, TMR16_FLAG_OFF, 8'h00);
        check(rdData, 8'h00, "reset flags");
        $display("test reset done");
        apb(1'b1, TMR16_CNTH_OFF, 8'h01);
        apb(1'b1, TMR16_CNTL_OFF, 8'hff);
        check(lastCv, 16'h01ff, "word write");
        ticks(5);
        check(counterValue, 16'h01ff, "stopped");
        apb(1'b1, TMR16_CMPH_OFF, 8'h77);
        apb(1'b0, TMR16_CNTL_OFF, 8'h00);
        check(rdData, 8'hff, "low read");
        apb(1'b0, TMR16_CNTH_OFF, 8'h00);
        check(rdData, 8'h01, "high via temp");
        $display("test byte access done");
        apb(1'b1, TMR16_CTRLB_OFF, 8'h01);
        ticks(3);
        check(counterValue, 16'h0202, "count up");
        apb(1'b1, TMR16_CNTH_OFF, 8'hff);
        apb(1'b1, TMR16_CNTL_OFF, 8'hfe);
        ticks(2);
        check(counterValue, 16'h0000, "wrap");
        apb(1'b1, TMR16_MASK_OFF, 8'h01);
        apb(1'b0, TMR16_FLAG_OFF, 8'h00);
        check(rdData, 8'h01, "ovf flag");
        check(ovfIrq, 1'b1, "ovf irq");
        apb(1'b1, TMR16_FLAG_OFF, 8'h01);
        check(ovfIrq, 1'b0, "ovf cleared");
        apb(1'b1, TMR16_CTRLA_OFF, 8'h01);
        apb(1'b1, TMR16_CNTH_OFF, 8'h00);
        apb(1'b1, TMR16_CNTL_OFF, 8'hfe);
        ticks(3);
        check(counterValue, 16'h00fd, "turn at top");
        apb(1'b1, TMR16_CTRLA_OFF, 8'h00);
        $display("test counting done");
        strobe <= 1'b1;
        apb(1'b1, TMR16_CNTH_OFF, 8'h12);
        apb(1'b1, TMR16_CNTL_OFF, 8'h34);
        strobe <= 1'b0;
        check(lastCv, 16'h1234, "write beats count");
        apb(1'b1, TMR16_CNTH_OFF, 8'hab);
        apb(1'b1, TMR16_CNTL_OFF, 8'h01);
        check(lastCv, 16'hab01, "first word");
        apb(1'b1, TMR16_CNTL_OFF, 8'h02);
        check(lastCv, 16'hab02, "temp reused");
        apb(1'b1, TMR16_CMPH_OFF, 8'h12);
        apb(1'b1, TMR16_CMPL_OFF, 8'h34);
        apb(1'b0, TMR16_CNTL_OFF, 8'h00);
        apb(1'b0, TMR16_CMPH_OFF, 8'h00);
        check(rdData, 8'h12, "compare direct");
        apb(1'b0, TMR16_CNTH_OFF, 8'h00);
        check(rdData, 8'hab, "temp untouched");
        $display("test temp done");
        apb(1'b1, TMR16_CTRLB_OFF, 8'h41);
        capPin <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b1, TMR16_CMPH_OFF, 8'h77);
        apb(1'b0, TMR16_CAPL_OFF, 8'h00);
        check(rdData, 8'h02, "capture low");
        apb(1'b0, TMR16_CAPH_OFF, 8'h00);
        check(rdData, 8'hab, "capture high");
        apb(1'b0, TMR16_FLAG_OFF, 8'h00);
        check(rdData, 8'h02, "cap flag");
        apb(1'b1, TMR16_FLAG_OFF, 8'h02);
        apb(1'b0, TMR16_FLAG_OFF, 8'h00);
        check(rdData, 8'h00, "cap flag cleared");
        capPin <= 1'b0;
        repeat (3) @(posedge clock);
        apb(1'b0, TMR16_FLAG_OFF, 8'h00);
        check(rdData, 8'h00, "wrong edge");
        apb(1'b1, TMR16_CTRLB_OFF, 8'hc1);
        cmpOut <= 1'b1;
        repeat (3) @(posedge clock);
        apb(1'b1, TMR16_MASK_OFF, 8'h02);
        check(capIrq, 1'b1, "comparator capture");
        ackEnable <= 1'b1;
        repeat (10) @(posedge clock);
        check(capIrq, 1'b0, "ack clears");
        $display("test capture done");
        apb(1'b1, TMR16_CTRLB_OFF, 8'h01);
        apb(1'b1, TMR16_CAPH_OFF, 8'h55);
        apb(1'b1, TMR16_CAPL_OFF, 8'h66);
        apb(1'b0, TMR16_CAPL_OFF, 8'h00);
        check(rdData, 8'h02, "capture locked");
        apb(1'b1, TMR16_CTRLB_OFF, 8'h19);
        apb(1'b1, TMR16_CAPH_OFF, 8'h55);
        apb(1'b1, TMR16_CAPL_OFF, 8'h66);
        apb(1'b0, TMR16_CAPL_OFF, 8'h00);
        check(rdData, 8'h66, "top low");
        apb(1'b0, TMR16_CAPH_OFF, 8'h00);
        check(rdData, 8'h55, "top high");
        apb(1'b0, 8'h3c, 8'h00);
        check(rdData, 8'h00, "unmapped");
        $display("test capture top done");
        report_and_stop();
    end
endmodule : tmr16_core_tb
